// File: rtl/cbs_pkg.sv
// Purpose: shared constants and types of the conditional branch/skip unit
// Assumes: AHB-Lite register access, 32-bit data, word registers
// Notes:   one word per register, byte addresses below
`default_nettype none
package cbs_pkg;
	// =====================================================================
	// register map
	localparam logic [7:0]  CBS_OFF_CMD    = 8'h00;
	localparam logic [7:0]  CBS_OFF_PC     = 8'h04;
	localparam logic [7:0]  CBS_OFF_FLAGS  = 8'h08;
	localparam logic [7:0]  CBS_OFF_IOVAL  = 8'h0c;
	localparam logic [7:0]  CBS_OFF_STATUS = 8'h10;
	// =====================================================================
	// reset values
	localparam logic [15:0] CBS_PC_RST     = 16'h0000;
	localparam logic [7:0]  CBS_FLAGS_RST  = 8'h00;
	localparam logic [7:0]  CBS_IOVAL_RST  = 8'h00;
	localparam logic [14:0] CBS_CMD_RST    = 15'h0000;
	// =====================================================================
	// status flag positions
	localparam int          CBS_FLAG_C     = 0;
	localparam int          CBS_FLAG_Z     = 1;
	localparam int          CBS_FLAG_N     = 2;
	// status register field positions
	localparam int          CBS_ST_BUSY    = 0;
	localparam int          CBS_ST_TAKEN   = 1;
	localparam int          CBS_ST_CYC_LO  = 2;
	// =====================================================================
	// cycle counts and program counter steps
	localparam logic [1:0]  CBS_CYC_SEQ    = 2'h1;
	localparam logic [1:0]  CBS_CYC_BRANCH = 2'h2;
	localparam logic [1:0]  CBS_CYC_SKIP1  = 2'h2;
	localparam logic [1:0]  CBS_CYC_SKIP2  = 2'h3;
	localparam logic [15:0] CBS_STEP_SEQ   = 16'h0001;
	localparam logic [15:0] CBS_STEP_SKIP1 = 16'h0002;
	localparam logic [15:0] CBS_STEP_SKIP2 = 16'h0003;
	// =====================================================================
	// types
	typedef enum logic [3:0] {
		CBS_OP_SKIP_IO_CLEAR,
		CBS_OP_SKIP_IO_SET,
		CBS_OP_FLAG_SET,
		CBS_OP_FLAG_CLEAR,
		CBS_OP_ZERO,
		CBS_OP_NONZERO,
		CBS_OP_CARRY,
		CBS_OP_NO_CARRY,
		CBS_OP_UGE,
		CBS_OP_ULT,
		CBS_OP_NEGATIVE,
		CBS_OP_POSITIVE
	} cbs_op_t;
	typedef enum logic {CBS_IDLE, CBS_EXEC} cbs_state_t;
	typedef struct packed {
		logic [6:0] k;
		logic       two_word;
		logic [2:0] sel;
		logic [3:0] op;
	} cbs_cmd_t;
	typedef struct packed {
		logic [7:0] addr;
		logic       hit;
		logic       wr;
		logic       rd;
	} cbs_aphase_t;
endpackage
`default_nettype wire

// File: rtl/cbs_unit.sv
// Purpose: conditional branch and skip decision unit with AHB-Lite registers
// Assumes: single word transfers, one clock, asynchronous active-low reset
// Notes:   a command write while idle starts one instruction; pc updates when it ends
`default_nettype none
module cbs_unit
	import cbs_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output var  logic        hreadyout,
	output var  logic [31:0] hrdata,
	output var  logic        hresp,
	output var  logic [15:0] pc_value,
	output var  logic        exec_busy,
	output var  logic        exec_done
);

	// =====================================================================
	// helpers
	function automatic logic is_reg(input cbs_aphase_t a,
		input logic [7:0] off);
		is_reg = a.hit && (a.addr == off);
	endfunction

	function automatic logic [15:0] sext_k(input logic [6:0] k);
		sext_k = {{9{k[6]}}, k};
	endfunction

	// =====================================================================
	// state
	cbs_aphase_t ap;
	cbs_state_t  state;
	logic [14:0] cmd_reg;
	logic [7:0]  flags;
	logic [7:0]  ioval;
	logic [15:0] tgt;
	logic [1:0]  cnt;
	logic        taken;
	logic [1:0]  cyc_last;

	// =====================================================================
	// decode of the command being written
	cbs_cmd_t    cmd_in;
	cbs_op_t     op;
	logic        cond;
	logic        is_skip;
	logic [15:0] delta;
	logic [1:0]  cyc;
	logic        take;
	logic        wr_now;
	logic        start;
	logic        idle_wr;

	assign cmd_in  = cbs_cmd_t'(hwdata[14:0]);
	assign op      = cbs_op_t'(cmd_in.op);
	assign take    = hsel && hready && htrans[1];
	assign wr_now  = ap.wr && hreadyout;
	assign start   = wr_now && is_reg(ap, CBS_OFF_CMD) && (state == CBS_IDLE);
	assign idle_wr = wr_now && (state == CBS_IDLE);

	always_comb begin
		cond    = 1'b0;
		is_skip = 1'b0;
		unique case (op)
			CBS_OP_SKIP_IO_CLEAR: begin
				cond    = !ioval[cmd_in.sel];
				is_skip = 1'b1;
			end
			CBS_OP_SKIP_IO_SET: begin
				cond    = ioval[cmd_in.sel];
				is_skip = 1'b1;
			end
			CBS_OP_FLAG_SET:   cond = flags[cmd_in.sel];
			CBS_OP_FLAG_CLEAR: cond = !flags[cmd_in.sel];
			CBS_OP_ZERO:       cond = flags[CBS_FLAG_Z];
			CBS_OP_NONZERO:    cond = !flags[CBS_FLAG_Z];
			CBS_OP_CARRY:      cond = flags[CBS_FLAG_C];
			CBS_OP_ULT:        cond = flags[CBS_FLAG_C];
			CBS_OP_NO_CARRY:   cond = !flags[CBS_FLAG_C];
			CBS_OP_UGE:        cond = !flags[CBS_FLAG_C];
			CBS_OP_NEGATIVE:   cond = flags[CBS_FLAG_N];
			CBS_OP_POSITIVE:   cond = !flags[CBS_FLAG_N];
			default:           cond = 1'b0;
		endcase
	end

	always_comb begin
		if (!cond) begin
			delta = CBS_STEP_SEQ;
			cyc   = CBS_CYC_SEQ;
		end else if (is_skip) begin
			delta = cmd_in.two_word ? CBS_STEP_SKIP2 : CBS_STEP_SKIP1;
			cyc   = cmd_in.two_word ? CBS_CYC_SKIP2 : CBS_CYC_SKIP1;
		end else begin
			delta = sext_k(cmd_in.k) + CBS_STEP_SEQ;
			cyc   = CBS_CYC_BRANCH;
		end
	end

	// =====================================================================
	// bus slave
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ap <= '0;
		end else if (take) begin
			ap.addr <= haddr[7:0];
			ap.hit  <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'h0);
			ap.wr   <= hwrite;
			ap.rd   <= !hwrite;
		end else begin
			ap <= '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
		end else begin
			hreadyout <= !(take && !hwrite);
			hresp     <= 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h00000000;
		end else if (ap.rd && !hreadyout) begin
			hrdata <= 32'h00000000;
			if (is_reg(ap, CBS_OFF_CMD))
				hrdata[14:0] <= cmd_reg;
			if (is_reg(ap, CBS_OFF_PC))
				hrdata[15:0] <= pc_value;
			if (is_reg(ap, CBS_OFF_FLAGS))
				hrdata[7:0] <= flags;
			if (is_reg(ap, CBS_OFF_IOVAL))
				hrdata[7:0] <= ioval;
			if (is_reg(ap, CBS_OFF_STATUS)) begin
				hrdata[CBS_ST_BUSY]  <= exec_busy;
				hrdata[CBS_ST_TAKEN] <= taken;
				hrdata[CBS_ST_CYC_LO +: 2] <= cyc_last;
			end
		end
	end

	// =====================================================================
	// software registers, writable only while idle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags   <= CBS_FLAGS_RST;
			ioval   <= CBS_IOVAL_RST;
			cmd_reg <= CBS_CMD_RST;
		end else if (idle_wr) begin
			if (is_reg(ap, CBS_OFF_FLAGS))
				flags <= hwdata[7:0];
			if (is_reg(ap, CBS_OFF_IOVAL))
				ioval <= hwdata[7:0];
			if (is_reg(ap, CBS_OFF_CMD))
				cmd_reg <= hwdata[14:0];
		end
	end

	// =====================================================================
	// execution sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state     <= CBS_IDLE;
			exec_busy <= 1'b0;
			exec_done <= 1'b0;
			cnt       <= 2'h0;
			tgt       <= CBS_PC_RST;
			taken     <= 1'b0;
			cyc_last  <= 2'h0;
		end else begin
			exec_done <= 1'b0;
			unique case (state)
				CBS_IDLE: begin
					if (start) begin
						state     <= CBS_EXEC;
						exec_busy <= 1'b1;
						tgt       <= pc_value + delta;
						cnt       <= cyc - 2'h1;
						taken     <= cond;
						cyc_last  <= cyc;
					end
				end
				CBS_EXEC: begin
					if (cnt == 2'h0) begin
						state     <= CBS_IDLE;
						exec_busy <= 1'b0;
						exec_done <= 1'b1;
					end else begin
						cnt <= cnt - 2'h1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_value <= CBS_PC_RST;
		end else if (state == CBS_EXEC && cnt == 2'h0) begin
			pc_value <= tgt;
		end else if (idle_wr && is_reg(ap, CBS_OFF_PC)) begin
			pc_value <= hwdata[15:0];
		end
	end

	// =====================================================================
	// assertions
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	logic [15:0] k_ext;
	assign k_ext = sext_k(cmd_in.k);

	AST_SKIP_CLEAR_TWO: assert property (
		start && op == CBS_OP_SKIP_IO_CLEAR && !ioval[cmd_in.sel]
			&& cmd_in.two_word
		|-> ##1 exec_busy [*3] ##1 exec_done
			&& pc_value == $past(pc_value, 4) + CBS_STEP_SKIP2)
		else $error("skip on clear bit did not step pc by 3");
	AST_SKIP_SET_ONE: assert property (
		start && op == CBS_OP_SKIP_IO_SET && ioval[cmd_in.sel]
			&& !cmd_in.two_word
		|-> ##1 exec_busy [*2] ##1 exec_done
			&& pc_value == $past(pc_value, 3) + CBS_STEP_SKIP1)
		else $error("skip on set bit did not step pc by 2");
	AST_FLAG_SET: assert property (
		start && op == CBS_OP_FLAG_SET && flags[cmd_in.sel]
		|-> ##3 exec_done && pc_value == $past(pc_value, 3)
			+ $past(k_ext, 3) + CBS_STEP_SEQ)
		else $error("flag-set branch target wrong");
	AST_FLAG_CLEAR: assert property (
		start && op == CBS_OP_FLAG_CLEAR && !flags[cmd_in.sel]
		|-> ##3 exec_done && flags == $past(flags, 3)
			&& pc_value == $past(pc_value, 3) + $past(k_ext, 3) + CBS_STEP_SEQ)
		else $error("flag-clear branch wrong or flags altered");
	AST_ZERO_NOT_TAKEN: assert property (
		start && op == CBS_OP_ZERO && !flags[CBS_FLAG_Z]
		|-> ##2 exec_done && pc_value == $past(pc_value, 2) + CBS_STEP_SEQ)
		else $error("zero branch taken without zero flag");
	AST_NONZERO: assert property (
		start && op == CBS_OP_NONZERO && !flags[CBS_FLAG_Z]
		|-> ##3 exec_done && flags == $past(flags, 3) && taken)
		else $error("nonzero branch not taken");
	AST_CARRY: assert property (
		start && (op == CBS_OP_CARRY || op == CBS_OP_ULT) && flags[CBS_FLAG_C]
		|-> ##3 exec_done && pc_value == $past(pc_value, 3)
			+ $past(k_ext, 3) + CBS_STEP_SEQ)
		else $error("carry branch target wrong");
	AST_NO_CARRY_FALL: assert property (
		start && op == CBS_OP_NO_CARRY && flags[CBS_FLAG_C]
		|-> ##2 exec_done && !taken && cyc_last == CBS_CYC_SEQ)
		else $error("no-carry branch taken with carry set");
	AST_UGE: assert property (
		start && op == CBS_OP_UGE && !flags[CBS_FLAG_C]
		|-> ##3 exec_done && taken && cyc_last == CBS_CYC_BRANCH)
		else $error("unsigned same-or-higher branch not taken");
	AST_NEGATIVE: assert property (
		start && op == CBS_OP_NEGATIVE && flags[CBS_FLAG_N]
		|-> ##1 exec_busy ##2 exec_done && taken)
		else $error("negative branch not taken");
	AST_POSITIVE: assert property (
		start && op == CBS_OP_POSITIVE && !flags[CBS_FLAG_N]
		|-> ##3 exec_done && taken && flags == $past(flags, 3))
		else $error("positive branch wrong or flags altered");
	AST_BACKWARD: assert property (
		start && cond && !is_skip && cmd_in.k[6]
		|-> ##3 pc_value + {9'h000, $past(~cmd_in.k + 7'h01, 3)}
			== $past(pc_value, 3) + CBS_STEP_SEQ)
		else $error("backward branch target wrong");

	COV_SKIP_TWO: cover property (start && is_skip && cond && cmd_in.two_word);
	COV_BACKWARD: cover property (start && cond && !is_skip && cmd_in.k[6]);
	COV_NOT_TAKEN: cover property (start && !cond ##2 exec_done);
	COV_STATUS_RD: cover property (ap.rd && is_reg(ap, CBS_OFF_STATUS));

endmodule
`default_nettype wire

// File: tb/cbs_unit_test.sv
// Purpose: self-checking bench of the conditional branch/skip unit
// Assumes: hready fed back from hreadyout, single word transfers
// Notes:   driver queues expected pc and cycle count, monitor compares
`default_nettype none
module cbs_unit_test
	import cbs_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// =====================================================================
	// signals
	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic [15:0] pc_value;
	logic        exec_busy;
	logic        exec_done;
	int          err_total;
	int          checks;
	int          seed;
	int          cyc;
	logic [15:0] exp_pc[$];
	logic [1:0]  exp_n[$];
	// =====================================================================
	// design
	cbs_unit i_dut (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.hsel      (hsel),
		.haddr     (haddr),
		.htrans    (htrans),
		.hwrite    (hwrite),
		.hsize     (hsize),
		.hwdata    (hwdata),
		.hready    (hreadyout),
		.hreadyout (hreadyout),
		.hrdata    (hrdata),
		.hresp     (hresp),
		.pc_value  (pc_value),
		.exec_busy (exec_busy),
		.exec_done (exec_done)
	);
	initial begin
		hclk = 1'b0;
		forever #2.5 hclk = ~hclk;
	end
	// =====================================================================
	// checking and closing
	task automatic chk(input string name, input logic [31:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize;
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// =====================================================================
	// bus master
	task automatic wait_rdy(output logic [31:0] rd);
		int i;
		for (i = 0; i < 20; i++) begin
			@(posedge hclk);
			if (hreadyout === 1'b1)
				break;
		end
		rd = hrdata;
		if (i == 20) begin
			err_total++;
			summarize();
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a,
			input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		wait_rdy(rd);
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy(rd);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] rd;
		bus(1'b1, a, d, rd);
	endtask
	task automatic rd_chk(input string n, input logic [7:0] a,
			input logic [31:0] e);
		logic [31:0] rd;
		bus(1'b0, a, 32'h0, rd);
		chk(n, rd, e);
		chk("hresp", {31'h0, hresp}, 32'h0);
	endtask
	// =====================================================================
	// one instruction: expectation, setup, command, completion
	task automatic run(input logic [3:0] op, input logic [2:0] sel,
			input logic [6:0] k, input logic two, input logic [7:0] fl,
			input logic [7:0] io, input logic [15:0] pc, input logic poke);
		logic        c;
		logic [15:0] tgt;
		logic [1:0]  n;
		int          i;
		case (op)
			4'd0: c = !io[sel];
			4'd1: c = io[sel];
			4'd2: c = fl[sel];
			4'd3: c = !fl[sel];
			4'd4: c = fl[CBS_FLAG_Z];
			4'd5: c = !fl[CBS_FLAG_Z];
			4'd6, 4'd9: c = fl[CBS_FLAG_C];
			4'd7, 4'd8: c = !fl[CBS_FLAG_C];
			4'd10: c = fl[CBS_FLAG_N];
			4'd11: c = !fl[CBS_FLAG_N];
			default: c = 1'b0;
		endcase
		tgt = pc + 16'h0001;
		n = 2'h1;
		if (c && op < 4'd2) begin
			tgt = pc + (two ? 16'h0003 : 16'h0002);
			n = two ? 2'h3 : 2'h2;
		end else if (c) begin
			tgt = pc + {{9{k[6]}}, k} + 16'h0001;
			n = 2'h2;
		end
		wr(CBS_OFF_FLAGS, {24'h0, fl});
		wr(CBS_OFF_IOVAL, {24'h0, io});
		wr(CBS_OFF_PC, {16'h0, pc});
		exp_pc.push_back(tgt);
		exp_n.push_back(n);
		wr(CBS_OFF_CMD, {17'h0, k, two, sel, op});
		if (poke)
			wr(CBS_OFF_PC, 32'h0000_5a5a);
		for (i = 0; i < 20 && exp_pc.size() != 0; i++)
			@(posedge hclk);
		if (i == 20) begin
			chk("exec_done_seen", 32'h0, 32'h1);
			summarize();
		end
		rd_chk("flags_kept", CBS_OFF_FLAGS, {24'h0, fl});
		rd_chk("pc_reg", CBS_OFF_PC, {16'h0, tgt});
	endtask
	// =====================================================================
	// monitor: busy cycles and pc at completion
	always @(negedge hclk) begin
		if (exec_busy === 1'b1)
			cyc++;
		if (exec_done === 1'b1) begin
			if (exp_pc.size() == 0)
				chk("unexpected_done", 32'h1, 32'h0);
			else begin
				chk("pc_value", {16'h0, pc_value}, {16'h0, exp_pc.pop_front()});
				chk("cycles", cyc, {30'h0, exp_n.pop_front()});
			end
			cyc = 0;
		end
	end
	// =====================================================================
	// main sequence
	initial begin
		logic [31:0] r;
		logic [7:0]  fl;
		logic [7:0]  io;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0;
		seed = 32'h133d8225;
		err_total = 0;
		checks = 0;
		cyc = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		for (int i = 0; i < 6; i++)
			rd_chk("reset_value", 8'(i * 4), 32'h0);
		wr(8'h14, 32'hffff_ffff);
		rd_chk("unmapped", 8'h14, 32'h0);
		wr(CBS_OFF_STATUS, 32'hffff_ffff);
		rd_chk("status_ro", CBS_OFF_STATUS, 32'h0);
		run(4'd2, 3'd0, 7'h40, 1'b0, 8'h01, 8'h00, 16'h0010, 1'b1);
		run(4'd5, 3'd0, 7'h3f, 1'b0, 8'h00, 8'h00, 16'hfff0, 1'b1);
		run(4'd0, 3'd7, 7'h00, 1'b1, 8'h00, 8'h7f, 16'h0100, 1'b1);
		for (int i = 0; i < 64; i++) begin
			r = $random(seed);
			fl = i[4] ? 8'hff : 8'h00;
			io = i[5] ? 8'hff : 8'h00;
			run(i[3:0], r[2:0], r[9:3], r[10], fl, io, r[31:16], 1'b0);
		end
		summarize();
	end
endmodule
`default_nettype wire
